// ### rtl/fsw_pkg.sv
// Package with status layout, command codes and timing for the flash status block
package fsw_pkg;
  // Array organisation
  localparam int SECTOR_BYTES = 4096;
  localparam int BLK32_SECTORS = 8;
  localparam int BLK64_SECTORS = 16;
  localparam int ADDR_BITS = 24;
  localparam int NUM_BLK64 = 128;
  // Address field positions
  localparam int SECTOR_MSB = 22;
  localparam int SECTOR_LSB = 12;
  localparam int BLK32_LSB = 15;
  localparam int BLK64_LSB = 16;
  // Status byte layout, reset value all zero
  typedef struct packed {
    logic status_write_lock;
    logic quad_enable;
    logic [3:0] block_protect;
    logic write_enable_latch;
    logic busy_flag;
  } fsw_status_type;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int NV_MSB = 7;
  localparam int NV_LSB = 2;
  // Command codes
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_WRITE_FUNCTION = 8'h42;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_QUAD_PROGRAM_A = 8'h32;
  localparam logic [7:0] CMD_QUAD_PROGRAM_B = 8'h38;
  localparam logic [7:0] CMD_PROGRAM_INFO_ROW = 8'h62;
  localparam logic [7:0] CMD_SECTOR_ERASE_A = 8'hd7;
  localparam logic [7:0] CMD_SECTOR_ERASE_B = 8'h20;
  localparam logic [7:0] CMD_BLOCK_ERASE_32K = 8'h52;
  localparam logic [7:0] CMD_BLOCK_ERASE_64K = 8'hd8;
  localparam logic [7:0] CMD_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] CMD_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] CMD_ERASE_INFO_ROW = 8'h64;
  // Byte counts of complete frames
  localparam logic [2:0] BYTES_CMD = 3'h1;
  localparam logic [2:0] BYTES_REG = 3'h2;
  localparam logic [2:0] BYTES_ADDR = 3'h4;
  localparam logic [2:0] BYTES_PROG = 3'h5;
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int OP_TIME_NS = 10000;
  localparam int OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
  typedef enum logic {OP_IDLE, OP_BUSY} fsw_op_type;
endpackage

// ### rtl/fsw_status_ctrl.sv
// Serial flash status register and write-enable control
`timescale 1ns/1ps
module fsw_status_ctrl #(
  parameter int BUSY_CYCLES = fsw_pkg::OP_CYCLES
) (
  input wire logic ref_clk_i, // 20 MHz clock
  input wire logic reset_i, // Synchronous reset, high
  input wire logic sck_i, // Serial clock pin
  input wire logic cs_n_i, // Chip select pin, low active
  input wire logic si_i, // Serial data in
  input wire logic wp_n_i, // Write protect pin or data line 2
  input wire logic hold_n_i, // Hold pin or data line 3
  output logic so_o, // Serial data out
  output logic so_oe_o, // Serial data out enable
  output logic [7:0] status_o, // Status byte
  output logic quad_en_o, // Protect/hold pins act as data lines
  output logic op_start_o, // Pulse: array or register write starts
  output logic [7:0] op_code_o, // Command of started operation
  output logic [23:0] op_addr_o // Byte address of started operation
);
  fsw_pkg::fsw_status_type stat_q, stat_d;
  fsw_pkg::fsw_op_type op_q, op_d;
  logic [2:0] sck_s_q, cs_s_q;
  logic [1:0] si_s_q, wp_s_q, hold_s_q;
  logic [2:0] bit_idx_q, byte_cnt_q;
  logic [7:0] sh_q, cmd_q, data_q, rd_q;
  logic [23:0] addr_q;
  logic [31:0] cnt_q;
  logic so_q, so_oe_q, start_q;
  logic rd_on_q;
  logic [7:0] op_code_q;
  logic [23:0] op_addr_q;

  function automatic logic [6:0] blk64_of(input logic [23:0] a);
    blk64_of = a[fsw_pkg::SECTOR_MSB:fsw_pkg::BLK64_LSB];
  endfunction

  // Top-area protection: field n from 1 to 7 guards the highest 2^(n-1) blocks, 8 and above guard all
  function automatic logic prot(input logic [3:0] bp, input logic [6:0] b);
    logic [7:0] n;
    n = 8'h01 << (bp[2:0] - 3'h1);
    prot = bp[3] | ((bp != 4'h0) & ({1'b0, b} >= (8'h80 - n)));
  endfunction

  wire frame = ~cs_s_q[1];
  wire hold_act = ~stat_q.quad_enable & ~hold_s_q[1];
  wire sck_rise = frame & ~hold_act & sck_s_q[1] & ~sck_s_q[2];
  wire sck_fall = frame & ~hold_act & ~sck_s_q[1] & sck_s_q[2];
  wire cs_end = cs_s_q[1] & ~cs_s_q[2];
  wire [7:0] sh_d = {sh_q[6:0], si_s_q[1]};
  wire byte_done = sck_rise & (bit_idx_q == 3'h7);
  wire whole = cs_end & (bit_idx_q == 3'h0);
  wire done = (op_q == fsw_pkg::OP_BUSY) & (cnt_q == 32'h0);
  wire ready = ~stat_q.busy_flag;
  // Frame decode at select rise: byte counts and command classes
  wire n1 = byte_cnt_q == fsw_pkg::BYTES_CMD;
  wire n2 = byte_cnt_q == fsw_pkg::BYTES_REG;
  wire n4 = byte_cnt_q == fsw_pkg::BYTES_ADDR;
  wire np = byte_cnt_q >= fsw_pkg::BYTES_PROG;
  wire c_write_enable_cmd = whole & n1 & (cmd_q == fsw_pkg::CMD_WRITE_ENABLE);
  wire c_write_disable_cmd = whole & n1 & (cmd_q == fsw_pkg::CMD_WRITE_DISABLE);
  wire sr_locked = stat_q.status_write_lock & ~stat_q.quad_enable
    & ~wp_s_q[1];
  wire c_write_status_cmd = n2 & (cmd_q == fsw_pkg::CMD_WRITE_STATUS) & ~sr_locked;
  wire c_write_function_cmd = n2 & (cmd_q == fsw_pkg::CMD_WRITE_FUNCTION);
  wire is_prog = np & ((cmd_q == fsw_pkg::CMD_PAGE_PROGRAM)
    | (cmd_q == fsw_pkg::CMD_QUAD_PROGRAM_A)
    | (cmd_q == fsw_pkg::CMD_QUAD_PROGRAM_B));
  wire is_erase = n4 & ((cmd_q == fsw_pkg::CMD_SECTOR_ERASE_A)
    | (cmd_q == fsw_pkg::CMD_SECTOR_ERASE_B)
    | (cmd_q == fsw_pkg::CMD_BLOCK_ERASE_32K)
    | (cmd_q == fsw_pkg::CMD_BLOCK_ERASE_64K));
  wire prot_hit = prot(stat_q.block_protect, blk64_of(addr_q));
  wire c_array = (is_prog | is_erase) & ~prot_hit;
  wire c_chip = n1 & ((cmd_q == fsw_pkg::CMD_CHIP_ERASE_A)
    | (cmd_q == fsw_pkg::CMD_CHIP_ERASE_B))
    & (stat_q.block_protect == 4'h0);
  wire c_info = (np & (cmd_q == fsw_pkg::CMD_PROGRAM_INFO_ROW))
    | (n4 & (cmd_q == fsw_pkg::CMD_ERASE_INFO_ROW));
  // Every writing command is gated by the latch and by idle state
  wire start = whole & stat_q.write_enable_latch & ready
    & (c_write_status_cmd | c_write_function_cmd | c_array | c_chip | c_info);
  wire rd_cmd = (cmd_q == fsw_pkg::CMD_READ_STATUS)
    & (byte_cnt_q != 3'h0);
  wire rd_first = (byte_cnt_q == fsw_pkg::BYTES_CMD)
    & (bit_idx_q == 3'h0);
  wire [7:0] rd_src = rd_first ? stat_q : rd_q;
  wire rd_on = rd_on_q | (sck_fall & rd_cmd);

  always_comb begin
    stat_d = stat_q;
    if (c_write_disable_cmd | done) begin
      stat_d.write_enable_latch = 1'b0;
    end
    if (c_write_enable_cmd) begin
      stat_d.write_enable_latch = 1'b1;
    end
    if (start & c_write_status_cmd) begin
      stat_d[fsw_pkg::NV_MSB:fsw_pkg::NV_LSB] =
        data_q[fsw_pkg::NV_MSB:fsw_pkg::NV_LSB];
    end
    if (start) begin
      stat_d.busy_flag = 1'b1;
    end else if (done) begin
      stat_d.busy_flag = 1'b0;
    end
  end

  always_comb begin
    op_d = op_q;
    case (op_q)
      fsw_pkg::OP_IDLE: if (start) op_d = fsw_pkg::OP_BUSY;
      fsw_pkg::OP_BUSY: if (done) op_d = fsw_pkg::OP_IDLE;
      default: op_d = fsw_pkg::OP_IDLE;
    endcase
  end

  // Synchronisers: two flops per pin, a third one on sck and cs for edge detection
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sck_s_q <= 3'h0;
      cs_s_q <= 3'h7;
      si_s_q <= 2'h0;
      wp_s_q <= 2'h3;
      hold_s_q <= 2'h3;
    end else begin
      sck_s_q <= {sck_s_q[1:0], sck_i};
      cs_s_q <= {cs_s_q[1:0], cs_n_i};
      si_s_q <= {si_s_q[0], si_i};
      wp_s_q <= {wp_s_q[0], wp_n_i};
      hold_s_q <= {hold_s_q[0], hold_n_i};
    end
  end

  // Serial shifter: counts bits and bytes of the current frame
  always_ff @(posedge ref_clk_i) begin
    if (reset_i | ~frame) begin
      bit_idx_q <= 3'h0;
      byte_cnt_q <= 3'h0;
      sh_q <= 8'h00;
    end else if (sck_rise) begin
      sh_q <= sh_d;
      bit_idx_q <= bit_idx_q + 3'h1;
      if (byte_done && byte_cnt_q != 3'h7) begin
        byte_cnt_q <= byte_cnt_q + 3'h1;
      end
    end
  end

  // Command byte, first data byte and three address bytes
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cmd_q <= 8'h00;
      data_q <= 8'h00;
      addr_q <= 24'h0;
    end else if (byte_done) begin
      if (byte_cnt_q == 3'h0) begin
        cmd_q <= sh_d;
      end
      if (byte_cnt_q == 3'h1) begin
        data_q <= sh_d;
      end
      if (byte_cnt_q >= 3'h1 && byte_cnt_q <= 3'h3) begin
        addr_q <= {addr_q[15:0], sh_d};
      end
    end
  end

  // Operation timer and the record of the started operation
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      stat_q <= fsw_pkg::STATUS_RESET;
      op_q <= fsw_pkg::OP_IDLE;
      cnt_q <= 32'h0;
      start_q <= 1'b0;
      op_code_q <= 8'h00;
      op_addr_q <= 24'h0;
    end else begin
      stat_q <= stat_d;
      op_q <= op_d;
      start_q <= start;
      if (start) begin
        cnt_q <= 32'(BUSY_CYCLES - 1);
        op_code_q <= cmd_q;
        op_addr_q <= addr_q;
      end else if (cnt_q != 32'h0) begin
        cnt_q <= cnt_q - 32'h1;
      end
    end
  end

  // Status read-out, one snapshot per frame; a hold floats the pin and ignores clock edges
  always_ff @(posedge ref_clk_i) begin
    if (reset_i | ~frame) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
      rd_on_q <= 1'b0;
      rd_q <= 8'h00;
    end else begin
      rd_on_q <= rd_on;
      so_oe_q <= rd_on & ~hold_act;
      if (sck_fall & rd_cmd) begin
        so_q <= rd_src[3'h7 - bit_idx_q];
        if (rd_first) begin
          rd_q <= stat_q;
        end
      end
    end
  end

  assign so_o = so_q;
  assign so_oe_o = so_oe_q;
  assign status_o = stat_q;
  assign quad_en_o = stat_q.quad_enable;
  assign op_start_o = start_q;
  assign op_code_o = op_code_q;
  assign op_addr_o = op_addr_q;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  AST_WEL_SET: assert property (c_write_enable_cmd |=>
    stat_q.write_enable_latch)
    else $error("latch not set by enable");
  AST_WEL_WRITE_DISABLE_CMD: assert property (c_write_disable_cmd |=>
    !stat_q.write_enable_latch)
    else $error("latch not cleared by disable");
  AST_WEL_DONE: assert property (done && !c_write_enable_cmd |=>
    !stat_q.write_enable_latch && !stat_q.busy_flag)
    else $error("latch or busy kept after completion");
  AST_WRITE_STATUS_CMD_WEL: assert property (start && c_write_status_cmd |=>
    stat_q.write_enable_latch)
    else $error("status write changed latch");
  AST_WEL_KEEP: assert property (!c_write_enable_cmd && !c_write_disable_cmd && !done |=>
    $stable(stat_q.write_enable_latch))
    else $error("latch changed without enable or disable");
  AST_NEED_WEL: assert property ($rose(stat_q.busy_flag) |->
    $past(stat_q.write_enable_latch))
    else $error("operation started without latch");
  AST_START_IDLE: assert property (start |->
    stat_q.write_enable_latch && !stat_q.busy_flag)
    else $error("operation started while refused");
  AST_BUSY_HOLD: assert property ($rose(stat_q.busy_flag) |->
    stat_q.busy_flag[*8])
    else $error("busy dropped early");
  AST_START_BUSY: assert property ($rose(stat_q.busy_flag) |->
    op_start_o)
    else $error("busy rose without start pulse");
  AST_START_PULSE: assert property (op_start_o |=> !op_start_o)
    else $error("start pulse longer than one cycle");
  AST_NV_KEEP: assert property (!(start && c_write_status_cmd) |=>
    $stable(stat_q[fsw_pkg::NV_MSB:fsw_pkg::NV_LSB]))
    else $error("protect bits changed without status write");
  AST_WRITE_STATUS_CMD_OPEN: assert property (whole && c_write_status_cmd && ready
    && stat_q.write_enable_latch |-> start)
    else $error("unlocked status write refused");
  AST_CHIP_PROT: assert property (start && c_chip |->
    stat_q.block_protect == 4'h0)
    else $error("chip erase while protected");
  AST_LOCKED: assert property (sr_locked |=>
    stat_q[7:2] == $past(stat_q[7:2]))
    else $error("locked status changed");
  AST_PROT_AREA: assert property (start && (is_prog || is_erase) |->
    !prot_hit ##1 op_start_o)
    else $error("write to protected block");
  AST_OP_HOLD: assert property (!op_start_o |->
    $stable(op_code_o) && $stable(op_addr_o))
    else $error("operation outputs changed without start");
  AST_RD_OE: assert property (so_oe_o |->
    cmd_q == fsw_pkg::CMD_READ_STATUS)
    else $error("output driven outside status read");
  AST_RD_SNAP: assert property (frame && rd_cmd && !rd_first |=>
    $stable(rd_q))
    else $error("status snapshot changed within frame");
  AST_HOLD_OE: assert property (hold_act |=> !so_oe_o)
    else $error("output driven during hold");

  COV_WRITE_ENABLE_CMD: cover property (c_write_enable_cmd);
  COV_ERASE: cover property (start && is_erase);
  COV_READ_STATUS_CMD_REPEAT: cover property (rd_cmd && byte_cnt_q == 3'h3);
  COV_LOCKED_WRITE_STATUS_CMD: cover property (whole && n2 && sr_locked);
  COV_HOLD: cover property (frame && hold_act);
endmodule

// ### dv/fsw_host_model.sv
// Host SPI controller model issuing mode 0 command frames
`timescale 1ns/1ps
module fsw_host_model (
  input wire logic ref_clk_i, // Bench clock, paces the link
  input wire logic so_i, // Serial data from device
  output logic sck_o, // Serial clock, still outside frames
  output logic cs_n_o, // Chip select, low active
  output logic si_o // Serial data to device
);
  logic [15:0] rd_q;
  int half;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    rd_q = 16'h0000;
    half = 4;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Sends n bytes MSB first from d, then clocks r bytes back into rd_q
  task automatic frame(input logic [39:0] d, input int n, input int r);
    int i;
    tick(1);
    cs_n_o = 1'b0;
    for (i = 0; i < (n + r) * 8; i++) begin
      si_o = (i < n * 8) ? d[39-i] : ~si_o;
      tick(half);
      sck_o = 1'b1;
      if (i >= n * 8) rd_q = {rd_q[14:0], so_i};
      tick(half);
      sck_o = 1'b0;
    end
    tick(half);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    tick(8);
  endtask
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the flash status and write-enable block
`timescale 1ns/1ps
module tb_top;
  localparam int BUSY = 10;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wp_n_i = 1'b1;
  logic hold_n_i = 1'b1;
  logic sck, cs_n, si, so, so_oe, quad_en, op_start;
  logic [7:0] status, op_code;
  logic [23:0] op_addr;
  int num_errors = 0;
  int cmp_count = 0;
  int starts = 0;
  logic [7:0] codes [12] = '{8'h02, 8'h32, 8'h38, 8'h62, 8'hd7, 8'h20,
    8'h52, 8'hd8, 8'h64, 8'hc7, 8'h60, 8'h42};
  int nb [12] = '{5, 5, 5, 5, 4, 4, 4, 4, 4, 1, 1, 2};
  always #25 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (op_start === 1'b1) starts <= starts + 1;
  fsw_status_ctrl #(.BUSY_CYCLES(BUSY)) dut_u (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .sck_i(sck), .cs_n_i(cs_n),
    .si_i(si), .wp_n_i(wp_n_i), .hold_n_i(hold_n_i), .so_o(so),
    .so_oe_o(so_oe), .status_o(status), .quad_en_o(quad_en),
    .op_start_o(op_start), .op_code_o(op_code), .op_addr_o(op_addr));
  fsw_host_model host_u (.ref_clk_i(ref_clk_i), .so_i(so), .sck_o(sck),
    .cs_n_o(cs_n), .si_o(si));
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 100 && status[0] !== 1'b0; k++) @(negedge ref_clk_i);
    if (status[0] !== 1'b0) begin
      check(1, 0, "busy timeout");
      final_report();
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    host_u.frame({c, 32'h0}, 1, 0);
  endtask
  // Status write always preceded by its write enable
  task automatic write_status_cmd(input logic [7:0] d);
    cmd(8'h06);
    host_u.frame({8'h01, d, 24'h0}, 2, 0);
  endtask
  task automatic t_reset();
    check(status, 8'h00, "reset status");
    check(quad_en, 1'b0, "reset quad");
    check(so_oe, 1'b0, "reset drive");
    $display("test reset done");
  endtask
  task automatic t_latch();
    cmd(8'h06);
    check(status, 8'h02, "latch set");
    host_u.frame({8'h05, 32'h0}, 1, 2);
    check(host_u.rd_q, 16'h0202, "repeated status");
    check(so_oe, 1'b0, "drive off");
    cmd(8'h04);
    check(status, 8'h00, "latch clear");
    $display("test latch done");
  endtask
  task automatic t_refuse();
    int i, s0;
    for (i = 0; i < 12; i++) begin
      s0 = starts;
      host_u.frame({codes[i], 24'h010000, 8'ha5}, nb[i], 0);
      check(starts - s0, 0, "refused start");
      check(status, 8'h00, "refused status");
    end
    $display("test refuse done");
  endtask
  task automatic t_accept();
    int i, s0;
    for (i = 0; i < 12; i++) begin
      cmd(8'h06);
      s0 = starts;
      host_u.frame({codes[i], 24'h7f0000, 8'ha5}, nb[i], 0);
      check(starts - s0, 1, "start pulse");
      check(op_code, codes[i], "op code");
      if (nb[i] == 4) check(op_addr, 24'h7f0000, "op addr");
      check(status, 8'h03, "busy with latch");
      wait_idle();
      check(status, 8'h00, "done clears latch");
    end
    $display("test accept done");
  endtask
  task automatic t_protect();
    int s0;
    write_status_cmd(8'h3d);
    check(status, 8'h3f, "status write");
    wait_idle();
    check(status, 8'h3c, "after write");
    cmd(8'h06);
    s0 = starts;
    cmd(8'hc7);
    host_u.frame({8'hd8, 32'h0}, 4, 0);
    check(starts - s0, 0, "protected ops");
    check(status, 8'h3e, "latch kept");
    write_status_cmd(8'h04);
    wait_idle();
    cmd(8'h06);
    host_u.frame({8'hd8, 24'h7f0000, 8'h0}, 4, 0);
    check(starts - s0, 1, "top block refused");
    host_u.frame({8'hd8, 24'h7e0000, 8'h0}, 4, 0);
    check(starts - s0, 2, "lower block taken");
    check(op_addr, 24'h7e0000, "erase addr");
    wait_idle();
    $display("test protect done");
  endtask
  task automatic t_lock();
    int s0;
    write_status_cmd(8'h80);
    wait_idle();
    wp_n_i = 1'b0;
    s0 = starts;
    write_status_cmd(8'h00);
    check(starts - s0, 0, "locked write");
    check(status, 8'h82, "locked status");
    wp_n_i = 1'b1;
    host_u.frame({8'h01, 8'h40, 24'h0}, 2, 0);
    check(status, 8'h43, "unlocked write");
    wait_idle();
    check(quad_en, 1'b1, "quad on");
    hold_n_i = 1'b0;
    host_u.frame({8'h05, 32'h0}, 1, 2);
    check(host_u.rd_q, 16'h4040, "hold pin as data line");
    hold_n_i = 1'b1;
    write_status_cmd(8'h00);
    wait_idle();
    check(quad_en, 1'b0, "quad off");
    hold_n_i = 1'b0;
    cmd(8'h06);
    check(status, 8'h00, "hold pauses link");
    hold_n_i = 1'b1;
    $display("test lock done");
  endtask
  initial begin
    repeat (10) @(negedge ref_clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    t_reset();
    t_latch();
    t_refuse();
    t_accept();
    t_protect();
    t_lock();
    final_report();
  end
endmodule
